// ---- design/ttb_pkg.sv ----
package ttb_pkg;

  // apb byte offsets of the context bank registers
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_CAPS = 12'h004;
  localparam logic [11:0] OFF_TBL0_LO = 12'h020;
  localparam logic [11:0] OFF_TBL0_HI = 12'h024;
  localparam logic [11:0] OFF_TBL1_LO = 12'h028;
  localparam logic [11:0] OFF_TBL1_HI = 12'h02c;
  localparam logic [11:0] OFF_TBL_CTRL = 12'h030;
  localparam logic [11:0] OFF_ATTR_LO = 12'h038;
  localparam logic [11:0] OFF_ATTR_HI = 12'h03c;
  localparam logic [11:0] OFF_SYNC_STATE = 12'h040;
  localparam logic [11:0] OFF_CMD = 12'h044;

  // reset values (the hardware leaves them unpredictable; zero is used)
  localparam logic [63:0] RST_TBL_BASE = 64'h0;
  localparam logic [31:0] RST_TBL_CTRL = 32'h0;
  localparam logic [31:0] RST_ATTR = 32'h0;

  // table control field positions
  localparam int TC_LONG_FMT = 31;
  localparam int TC_SHARE1 = 28;
  localparam int TC_OUTER1 = 26;
  localparam int TC_INNER1 = 24;
  localparam int TC_WALK_DIS1 = 23;
  localparam int TC_TAG_SEL = 22;
  localparam int TC_SIZE1 = 16;
  localparam int TC_SHARE0 = 12;
  localparam int TC_OUTER0 = 10;
  localparam int TC_INNER0 = 8;
  localparam int TC_WALK_DIS0 = 7;
  localparam int TC_SIZE0 = 0;
  // table control bits that belong to table 1 (hidden in a second-stage bank)
  localparam logic [31:0] TC_TABLE1_MASK = 32'h7fff_0000;

  // table base field positions
  localparam int TB_SHORT_INNER_LO = 6;
  localparam int TB_SHORT_INNER_HI = 0;
  localparam int TB_SHORT_INNER_SEL = 5;
  localparam int TB_SHORT_OUTER = 3;
  localparam int TB_SHORT_VENDOR = 2;
  localparam int TB_SHORT_SHARED = 1;
  localparam int TB_TAG = 48;
  localparam logic [63:0] TB_SHORT_ATTR_MASK = 64'h0000_0000_0000_007b;
  localparam logic [63:0] TB_LONG_TAG_MASK = 64'h00ff_0000_0000_0000;
  localparam logic [3:0] SHORT_ALIGN_TOP = 4'he;
  localparam logic [3:0] LONG_ALIGN_BIG = 4'he;
  localparam logic [3:0] LONG_ALIGN_SMALL = 4'h5;

  // config and capability bits
  localparam int CFG_STAGE2 = 0;
  localparam int CAP_STAGE1 = 0;
  localparam int SYNC_PENDING = 0;

  // walk attribute encodings
  typedef enum logic [1:0] {SH_NONE, SH_UNPRED, SH_OUTER, SH_INNER} ttb_share_e;
  typedef enum logic [1:0] {CA_NONCACHE, CA_WB_WA, CA_WT, CA_WB_NWA} ttb_cache_e;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_FLUSH_ALL, CMD_FLUSH_TAG, CMD_FLUSH_VADDR, CMD_SYNC, CMD_XLATE_READ
  } ttb_cmd_e;

  // decoded attributes of one table, as the walker uses them
  typedef struct packed {
    logic [39:0] base;
    ttb_cache_e inner;
    ttb_cache_e outer;
    ttb_share_e share;
    logic walk_disable;
  } ttb_walk_s;

  // two-bit shareability code to enum
  function automatic ttb_share_e dec_share(input logic [1:0] code);
    unique case (code)
      2'h0: dec_share = SH_NONE;
      2'h1: dec_share = SH_UNPRED;
      2'h2: dec_share = SH_OUTER;
      2'h3: dec_share = SH_INNER;
    endcase
  endfunction

  // two-bit cacheability code to enum
  function automatic ttb_cache_e dec_cache(input logic [1:0] code);
    unique case (code)
      2'h0: dec_cache = CA_NONCACHE;
      2'h1: dec_cache = CA_WB_WA;
      2'h2: dec_cache = CA_WT;
      2'h3: dec_cache = CA_WB_NWA;
    endcase
  endfunction

  // lowest base address bit for the given format and region size
  function automatic logic [3:0] base_shift(input logic long_fmt, input logic [2:0] size);
    if (long_fmt) begin
      base_shift = (size > 3'h1) ? LONG_ALIGN_BIG - {1'b0, size} : LONG_ALIGN_SMALL - {1'b0, size};
    end else begin
      base_shift = SHORT_ALIGN_TOP - {1'b0, size};
    end
  endfunction

  // mask of the base address bits [top:shift]
  function automatic logic [63:0] base_mask(input logic long_fmt, input logic [3:0] shift);
    logic [63:0] top;
    top = long_fmt ? 64'h0000_00ff_ffff_ffff : 64'h0000_0000_ffff_ffff;
    base_mask = top & ~((64'h1 << shift) - 64'h1);
  endfunction

  // bits that hold state in the current format; all others read as zero
  function automatic logic [63:0] live_mask(input logic long_fmt, input logic [3:0] shift);
    live_mask = base_mask(long_fmt, shift) | (long_fmt ? TB_LONG_TAG_MASK : TB_SHORT_ATTR_MASK);
  endfunction

endpackage

// ---- design/ttb_walk_attr.sv ----
`timescale 1ns/1ps
`default_nettype none

// decodes one table base register into walk address and attributes
module ttb_walk_attr #(
  parameter bit TABLE1 = 1'b0
) (
  // current register contents
  input wire logic i_long_fmt,
  input wire logic [63:0] i_tbl_base,
  input wire logic [31:0] i_tbl_ctrl,
  // decoded result
  output ttb_pkg::ttb_walk_s o_walk
);
  import ttb_pkg::*;

  logic [2:0] size; // region size field of this table
  logic [3:0] shift; // lowest base bit
  logic [1:0] sh_f; // long format shareability
  logic [1:0] out_f; // long format outer cacheability
  logic [1:0] in_f; // long format inner cacheability
  logic [63:0] mask; // base address bits kept for this format and size

  // select this table's fields and decode them
  always_comb begin
    size = TABLE1 ? i_tbl_ctrl[TC_SIZE1 +: 3] : i_tbl_ctrl[TC_SIZE0 +: 3];
    sh_f = TABLE1 ? i_tbl_ctrl[TC_SHARE1 +: 2] : i_tbl_ctrl[TC_SHARE0 +: 2];
    out_f = TABLE1 ? i_tbl_ctrl[TC_OUTER1 +: 2] : i_tbl_ctrl[TC_OUTER0 +: 2];
    in_f = TABLE1 ? i_tbl_ctrl[TC_INNER1 +: 2] : i_tbl_ctrl[TC_INNER0 +: 2];
    // short format alignment uses zero size for table 1
    shift = base_shift(i_long_fmt, (TABLE1 && !i_long_fmt) ? 3'h0 : size);
    mask = base_mask(i_long_fmt, shift);
    o_walk.base = i_tbl_base[39:0] & mask[39:0];
    if (i_long_fmt) begin
      // long format: attributes come from the table control register
      o_walk.share = dec_share(sh_f);
      o_walk.outer = dec_cache(out_f);
      o_walk.inner = dec_cache(in_f);
      o_walk.walk_disable = TABLE1 ? i_tbl_ctrl[TC_WALK_DIS1] : i_tbl_ctrl[TC_WALK_DIS0];
    end else begin
      // short format: attributes come from the low base register bits
      // bit 0 is the upper half of the inner code, bit 6 the lower half
      o_walk.inner = dec_cache({i_tbl_base[TB_SHORT_INNER_HI],
                                i_tbl_base[TB_SHORT_INNER_LO]});
      o_walk.outer = dec_cache(i_tbl_base[TB_SHORT_OUTER +: 2]);
      if (!i_tbl_base[TB_SHORT_SHARED]) begin
        o_walk.share = SH_NONE;
      end else begin
        o_walk.share = i_tbl_base[TB_SHORT_INNER_SEL] ? SH_INNER : SH_OUTER;
      end
      o_walk.walk_disable = 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- design/ttb_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - shareability code: none, unpredictable, outer, inner
// - cacheability code: nc, wb-wa, wt, wb-nwa
// - two 64-bit rw table base registers
// - short format base bits 31 to 14-N
// - short inner cacheability from bits 6,0
// - short bit 5 picks outer or inner
// - short bits 4:3 outer cacheability
// - short bit 2 vendor bit, zero here
// - short bit 1 marks walks shareable
// - long bits 55:48 hold address space tag
// - tag select bit picks table tag
// - long base 39 to x, x from size
// - first stage presence shown in capability bit
// - second stage bank forces long format
// - second stage hides table 1 state
// - second stage lacks status and attribute registers
// - second stage ignores tlb and translate commands
// - long format enable selects table system
// - region size is three-bit unsigned field
module ttb_regs #(
  parameter bit STAGE1_CAP = 1'b1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // walker side
  input wire logic i_sync_done,
  output ttb_pkg::ttb_walk_s o_walk0,
  output ttb_pkg::ttb_walk_s o_walk1,
  output logic [7:0] o_address_space_tag,
  output logic o_long_format_enable,
  output logic o_cmd_valid,
  output ttb_pkg::ttb_cmd_e o_cmd
);
  import ttb_pkg::*;

  // register state
  logic [63:0] tbl0_q, tbl0_d; // table 0 base
  logic [63:0] tbl1_q, tbl1_d; // table 1 base
  logic [31:0] ctrl_q, ctrl_d; // table control
  logic [31:0] attr_lo_q, attr_lo_d; // attribute indirection low
  logic [31:0] attr_hi_q, attr_hi_d; // attribute indirection high
  logic stage2_q, stage2_d; // bank configured as second stage
  logic sync_q, sync_d; // tlb sync pending
  // bus answer state
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  // walker outputs
  ttb_walk_s walk0_q, walk0_d, walk1_q, walk1_d;
  logic [7:0] tag_q, tag_d;
  logic long_q, long_d;
  logic cmd_valid_q, cmd_valid_d;
  ttb_cmd_e cmd_q, cmd_d;
  // decoded views
  logic long_fmt; // effective format select
  logic [31:0] ctrl_view; // table control as read back
  logic [63:0] live0, live1; // bits that hold state in each base
  ttb_walk_s dec0, dec1; // combinational decode results
  logic setup; // apb setup phase
  logic access; // apb access phase that completes now
  logic absent; // address not mapped in the current bank type

  // decode a command code written by software
  function automatic ttb_cmd_e dec_cmd(input logic [2:0] code);
    unique case (code)
      3'h1: dec_cmd = CMD_FLUSH_ALL;
      3'h2: dec_cmd = CMD_FLUSH_TAG;
      3'h3: dec_cmd = CMD_FLUSH_VADDR;
      3'h4: dec_cmd = CMD_SYNC;
      3'h5: dec_cmd = CMD_XLATE_READ;
      default: dec_cmd = CMD_NONE;
    endcase
  endfunction

  // effective format and live masks
  always_comb begin
    long_fmt = stage2_q | ctrl_q[TC_LONG_FMT];
    ctrl_view = stage2_q ? (ctrl_q & ~TC_TABLE1_MASK) : ctrl_q;
    ctrl_view[TC_LONG_FMT] = long_fmt;
    live0 = live_mask(long_fmt, base_shift(long_fmt, ctrl_q[TC_SIZE0 +: 3]));
    live1 = stage2_q ? 64'h0 : live_mask(long_fmt, base_shift(long_fmt, 3'h0));
    if (long_fmt) begin
      live1 = stage2_q ? 64'h0 : live_mask(1'b1, base_shift(1'b1, ctrl_q[TC_SIZE1 +: 3]));
    end
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable & pready_q;
    // absent registers of a second-stage bank
    absent = stage2_q && (i_paddr == OFF_ATTR_LO || i_paddr == OFF_ATTR_HI ||
                          i_paddr == OFF_SYNC_STATE);
  end

  // attribute decode for each table
  ttb_walk_attr #(.TABLE1(1'b0)) u_dec0 (
    .i_long_fmt(long_fmt),
    .i_tbl_base(tbl0_q),
    .i_tbl_ctrl(ctrl_q),
    .o_walk(dec0)
  );
  ttb_walk_attr #(.TABLE1(1'b1)) u_dec1 (
    .i_long_fmt(long_fmt),
    .i_tbl_base(tbl1_q),
    .i_tbl_ctrl(ctrl_q),
    .o_walk(dec1)
  );

  // apb answer: data and error prepared in setup, pready in access
  always_comb begin
    prdata_d = 32'h0;
    pslverr_d = 1'b0;
    pready_d = setup; // one-cycle access phase
    if (setup) begin
      unique case (i_paddr)
        OFF_CONFIG: prdata_d[CFG_STAGE2] = stage2_q;
        OFF_CAPS: prdata_d[CAP_STAGE1] = STAGE1_CAP;
        OFF_TBL0_LO: prdata_d = tbl0_q[31:0] & live0[31:0];
        OFF_TBL0_HI: prdata_d = tbl0_q[63:32] & live0[63:32];
        OFF_TBL1_LO: prdata_d = tbl1_q[31:0] & live1[31:0];
        OFF_TBL1_HI: prdata_d = tbl1_q[63:32] & live1[63:32];
        OFF_TBL_CTRL: prdata_d = ctrl_view;
        OFF_ATTR_LO: prdata_d = attr_lo_q;
        OFF_ATTR_HI: prdata_d = attr_hi_q;
        OFF_SYNC_STATE: prdata_d[SYNC_PENDING] = sync_q;
        OFF_CMD: prdata_d = 32'h0; // write only
        default: pslverr_d = 1'b1; // unmapped
      endcase
      if (absent || (stage2_q && i_paddr == OFF_CMD)) begin
        pslverr_d = 1'b1;
        prdata_d = 32'h0;
      end
    end
  end

  // register writes, taken at the completing access edge
  always_comb begin
    tbl0_d = tbl0_q;
    tbl1_d = tbl1_q;
    ctrl_d = ctrl_q;
    attr_lo_d = attr_lo_q;
    attr_hi_d = attr_hi_q;
    stage2_d = stage2_q;
    cmd_valid_d = 1'b0;
    cmd_d = CMD_NONE;
    sync_d = sync_q & ~i_sync_done;
    if (access && i_pwrite && !pslverr_q) begin
      unique case (i_paddr)
        OFF_CONFIG: stage2_d = i_pwdata[CFG_STAGE2];
        OFF_TBL0_LO: tbl0_d[31:0] = i_pwdata;
        OFF_TBL0_HI: tbl0_d[63:32] = i_pwdata;
        OFF_TBL1_LO: begin
          if (!stage2_q) begin
            tbl1_d[31:0] = i_pwdata;
          end
        end
        OFF_TBL1_HI: begin
          if (!stage2_q) begin
            tbl1_d[63:32] = i_pwdata;
          end
        end
        OFF_TBL_CTRL: ctrl_d = stage2_q ? (i_pwdata & ~TC_TABLE1_MASK) : i_pwdata;
        OFF_ATTR_LO: attr_lo_d = i_pwdata;
        OFF_ATTR_HI: attr_hi_d = i_pwdata;
        OFF_CMD: begin
          cmd_d = dec_cmd(i_pwdata[2:0]);
          cmd_valid_d = (cmd_d != CMD_NONE);
          if (cmd_d == CMD_SYNC) begin
            sync_d = 1'b1; // set wins over done
          end
        end
        default: ;
      endcase
    end
    // the vendor bit carries no feature here and is never stored
    tbl0_d[TB_SHORT_VENDOR] = 1'b0;
    tbl1_d[TB_SHORT_VENDOR] = 1'b0;
  end

  // walker output values
  always_comb begin
    walk0_d = dec0;
    walk1_d = stage2_q ? '0 : dec1;
    long_d = long_fmt;
    tag_d = 8'h0;
    if (long_fmt) begin
      tag_d = (ctrl_q[TC_TAG_SEL] && !stage2_q) ? tbl1_q[TB_TAG +: 8]
                                                : tbl0_q[TB_TAG +: 8];
    end
  end

  // state registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tbl0_q <= RST_TBL_BASE;
      tbl1_q <= RST_TBL_BASE;
      ctrl_q <= RST_TBL_CTRL;
      attr_lo_q <= RST_ATTR;
      attr_hi_q <= RST_ATTR;
      stage2_q <= 1'b0;
      sync_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      walk0_q <= '0;
      walk1_q <= '0;
      tag_q <= 8'h0;
      long_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_q <= CMD_NONE;
    end else begin
      tbl0_q <= tbl0_d;
      tbl1_q <= tbl1_d;
      ctrl_q <= ctrl_d;
      attr_lo_q <= attr_lo_d;
      attr_hi_q <= attr_hi_d;
      stage2_q <= stage2_d;
      sync_q <= sync_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      walk0_q <= walk0_d;
      walk1_q <= walk1_d;
      tag_q <= tag_d;
      long_q <= long_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q <= cmd_d;
    end
  end

  // outputs straight from flops
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_walk0 = walk0_q;
  assign o_walk1 = walk1_q;
  assign o_address_space_tag = tag_q;
  assign o_long_format_enable = long_q;
  assign o_cmd_valid = cmd_valid_q;
  assign o_cmd = cmd_q;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  short_share_a: assert property (
    (!long_fmt && !tbl0_q[TB_SHORT_SHARED]) |=> o_walk0.share == SH_NONE)
    else $error("short format unshared walk not non-shareable");
  short_inner_a: assert property (
    (!long_fmt && tbl0_q[TB_SHORT_SHARED] && tbl0_q[TB_SHORT_INNER_SEL])
      |=> o_walk0.share == SH_INNER)
    else $error("short format inner select ignored");
  long_share_a: assert property (
    (long_fmt && ctrl_q[TC_SHARE0 +: 2] == 2'h2) |=> o_walk0.share == SH_OUTER)
    else $error("long format share code 10 not outer");
  long_cache_a: assert property (
    (long_fmt && ctrl_q[TC_OUTER0 +: 2] == 2'h1) |=> o_walk0.outer == CA_WB_WA)
    else $error("long format outer code 01 not write-back allocate");
  short_inner_cache_a: assert property (
    (!long_fmt && tbl0_q[TB_SHORT_INNER_LO] && !tbl0_q[TB_SHORT_INNER_HI])
      |=> o_walk0.inner == CA_WB_WA)
    else $error("short inner bits 6,0 misdecoded");
  tag_select_a: assert property (
    (long_fmt && !stage2_q && ctrl_q[TC_TAG_SEL])
      |=> o_address_space_tag == $past(tbl1_q[55:48]))
    else $error("tag not taken from table 1");
  stage2_long_a: assert property (
    stage2_q |=> o_long_format_enable)
    else $error("second stage bank not in long format");
  stage2_cmd_a: assert property (
    (stage2_q && access && i_pwrite && i_paddr == OFF_CMD) |=> !o_cmd_valid)
    else $error("command accepted in second stage bank");
  reserved_read_a: assert property (
    (setup && !long_fmt && i_paddr == OFF_TBL0_HI) |=> (o_pready && o_prdata == 32'h0))
    else $error("short format upper base bits not zero");
  short_align_a: assert property (
    (!long_fmt) |=> o_walk1.base[13:0] == 14'h0 || stage2_q)
    else $error("table 1 short base not aligned");
  apb_answer_a: assert property (
    setup |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle after setup");

  // short format outer and shareable decode
  short_outer_a: assert property (
    (!long_fmt && tbl0_q[TB_SHORT_OUTER +: 2] == 2'h2) |=> o_walk0.outer == CA_WT)
    else $error("short format outer code 10 not write-through");
  short_outer_share_a: assert property (
    (!long_fmt && tbl0_q[TB_SHORT_SHARED] && !tbl0_q[TB_SHORT_INNER_SEL])
      |=> o_walk0.share == SH_OUTER)
    else $error("short format shareable walk not outer");

  // long format base and walk disable, tag in both formats, and enable
  long_base_a: assert property (
    (long_fmt && ctrl_q[TC_SIZE0 +: 3] == 3'h0) |=> o_walk0.base[4:0] == 5'h0)
    else $error("long format base below bit 5 not clear");
  walk_disable_a: assert property (
    (long_fmt && ctrl_q[TC_WALK_DIS0]) |=> o_walk0.walk_disable)
    else $error("walk disable bit not passed on");
  tag_zero_sel_a: assert property (
    (long_fmt && !ctrl_q[TC_TAG_SEL]) |=> o_address_space_tag == $past(tbl0_q[55:48]))
    else $error("tag not taken from table 0");
  short_tag_a: assert property (
    !long_fmt |=> o_address_space_tag == 8'h0)
    else $error("tag shown in short format");
  long_enable_a: assert property (
    ctrl_q[TC_LONG_FMT] |=> o_long_format_enable)
    else $error("format enable bit not followed");

  // second stage bank and identification
  stage2_walk1_a: assert property (
    stage2_q |=> o_walk1 == '0)
    else $error("table 1 walk visible in second stage bank");
  absent_error_a: assert property (
    (setup && absent) |=> o_pslverr)
    else $error("absent register answered without error");
  cap_read_a: assert property (
    (setup && i_paddr == OFF_CAPS) |=> o_prdata[CAP_STAGE1] == STAGE1_CAP)
    else $error("capability bit misreported");
  // a sync command sets pending even when done arrives with it
  sync_set_a: assert property (
    (access && i_pwrite && !pslverr_q && i_paddr == OFF_CMD && i_pwdata[2:0] == 3'h4)
      |=> sync_q)
    else $error("sync command did not set pending");

  // main scenarios reached
  cover_write_c: cover property (access && i_pwrite && i_paddr == OFF_TBL0_LO);
  cover_stage2_c: cover property (stage2_q && access && absent);
  cover_long_c: cover property (long_fmt && ctrl_q[TC_TAG_SEL]);
  cover_short_c: cover property (!long_fmt && tbl0_q[TB_SHORT_SHARED]);
  cover_cmd_c: cover property (o_cmd_valid && o_cmd == CMD_SYNC);

endmodule

`default_nettype wire

// ---- tb/ttb_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

// self-checking bench for the table base register bank
module testbench;
  import ttb_pkg::*;

  localparam bit CAP = 1'b0; // capability value chosen apart from the default
  // clock, reset and apb master signals
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_sync_done = 1'b0;
  // design outputs
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  ttb_walk_s o_walk0;
  ttb_walk_s o_walk1;
  logic [7:0] o_address_space_tag;
  logic o_long_format_enable;
  logic o_cmd_valid;
  ttb_cmd_e o_cmd;
  // bookkeeping and last apb answer
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;

  // 40 mhz clock
  always #12.5 i_clock = ~i_clock;

  ttb_regs #(.STAGE1_CAP(CAP)) ttb_regs_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sync_done(i_sync_done),
    .o_walk0(o_walk0), .o_walk1(o_walk1), .o_address_space_tag(o_address_space_tag),
    .o_long_format_enable(o_long_format_enable), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd)
  );

  // compare one value and count it
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr_en;
    i_paddr <= addr;
    i_pwdata <= wdata;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("unexpected pready expected 1 seen %b", o_pready);
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // write that must be accepted without error
  task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
    apb(1'b1, addr, wdata);
    chk("write error", 64'h0, {63'h0, er});
  endtask

  // read and compare
  task automatic rdc(input string what, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(what, {32'h0, exp}, {32'h0, rd});
  endtask

  // let register changes reach the decoded outputs
  task automatic settle;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  // expected walk record: base, inner, outer, share, walk disable
  function automatic logic [63:0] walk_of(input logic [39:0] b, input logic [1:0] inr,
                                          input logic [1:0] outr, input logic [1:0] sh,
                                          input logic dis);
    return {17'h0, b, inr, outr, sh, dis};
  endfunction

  // reset values, capability bit, unmapped address
  task automatic t_reset;
    rdc("table0 lo reset", OFF_TBL0_LO, 32'h0);
    rdc("table1 hi reset", OFF_TBL1_HI, 32'h0);
    rdc("capability", OFF_CAPS, {31'h0, CAP});
    chk("walk0 reset", 64'h0, {17'h0, o_walk0});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 64'h1, {63'h0, er});
  endtask

  // short format: alignment, reserved bits and attribute decode
  task automatic t_short;
    logic [31:0] v;
    logic [1:0] sh;
    logic [63:0] w; // expected walk record
    wr(OFF_TBL_CTRL, 32'h0000_0002);
    wr(OFF_TBL0_LO, 32'hffff_ffff);
    rdc("table0 short lo", OFF_TBL0_LO, 32'hffff_f07b);
    wr(OFF_TBL0_HI, 32'hffff_ffff);
    rdc("table0 short hi", OFF_TBL0_HI, 32'h0);
    wr(OFF_TBL1_LO, 32'hffff_ffff);
    rdc("table1 short lo", OFF_TBL1_LO, 32'hffff_c07b);
    settle();
    w = walk_of(40'h00_ffff_c000, 2'h3, 2'h3, 2'h3, 1'b0);
    chk("walk1 short", w, {17'h0, o_walk1});
    for (int c = 0; c < 4; c++) begin
      v = 32'h1234_5000;
      v[4:3] = c[1:0];
      v[6] = c[0];
      v[0] = c[1];
      v[1] = (c != 0);
      v[5] = (c == 2);
      sh = (c == 0) ? 2'h0 : ((c == 2) ? 2'h3 : 2'h2);
      wr(OFF_TBL0_LO, v);
      settle();
      w = walk_of(40'h00_1234_5000, c[1:0], c[1:0], sh, 1'b0);
      chk("walk0 short", w, {17'h0, o_walk0});
      chk("format short", 64'h0, {63'h0, o_long_format_enable});
    end
  endtask

  // long format: size-driven alignment, tag field, control attributes, tag select
  task automatic t_long;
    logic [31:0] v;
    int x;
    logic [63:0] w; // expected walk record
    wr(OFF_TBL0_HI, 32'hffff_ffff);
    wr(OFF_TBL0_LO, 32'hffff_ffff);
    for (int s = 0; s < 8; s++) begin
      x = (s > 1) ? 14 - s : 5 - s;
      wr(OFF_TBL_CTRL, 32'h8000_0000 | s);
      rdc("table0 long lo", OFF_TBL0_LO, 32'hffff_ffff << x);
      rdc("table0 long hi", OFF_TBL0_HI, 32'h00ff_00ff);
      settle();
      w = walk_of({8'hff, 32'hffff_ffff << x}, 2'h0, 2'h0, 2'h0, 1'b0);
      chk("walk0 long base", w, {17'h0, o_walk0});
      chk("format long", 64'h1, {63'h0, o_long_format_enable});
    end
    for (int c = 0; c < 4; c++) begin
      v = 32'h8000_0000;
      v[13:12] = c[1:0];
      v[11:10] = c[1:0];
      v[9:8] = ~c[1:0];
      v[7] = c[0];
      wr(OFF_TBL_CTRL, v);
      settle();
      w = walk_of(40'hff_ffff_ffe0, ~c[1:0], c[1:0], c[1:0], c[0]);
      chk("walk0 long attr", w, {17'h0, o_walk0});
    end
    wr(OFF_TBL0_HI, 32'h0012_0000);
    wr(OFF_TBL1_HI, 32'h0034_0000);
    wr(OFF_TBL_CTRL, 32'h8000_0000);
    settle();
    chk("tag from table0", 64'h12, {56'h0, o_address_space_tag});
    wr(OFF_TBL_CTRL, 32'hb6c3_0000);
    settle();
    chk("tag from table1", 64'h34, {56'h0, o_address_space_tag});
    w = walk_of(40'h00_ffff_f800, 2'h2, 2'h1, 2'h3, 1'b1);
    chk("walk1 long", w, {17'h0, o_walk1});
  endtask

  // watch the command strobe for a few cycles after a command write
  task automatic cmd_watch(input int exp_n, input logic [2:0] exp_code);
    int p;
    logic [2:0] code;
    p = 0;
    code = 3'h0;
    repeat (3) begin
      #1;
      if (o_cmd_valid === 1'b1) begin
        p++;
        code = o_cmd;
      end
      @(posedge i_clock);
    end
    chk("command pulses", exp_n, p);
    chk("command code", {61'h0, exp_code}, {61'h0, code});
  endtask

  // every command code, an illegal one, and the sync handshake
  task automatic t_cmd;
    for (int c = 1; c < 7; c++) begin
      apb(1'b1, OFF_CMD, c);
      cmd_watch((c < 6) ? 1 : 0, (c < 6) ? c[2:0] : 3'h0);
    end
    wr(OFF_CMD, 32'h4);
    rdc("sync pending set", OFF_SYNC_STATE, 32'h1);
    @(posedge i_clock);
    i_sync_done <= 1'b1;
    @(posedge i_clock);
    i_sync_done <= 1'b0;
    rdc("sync pending clear", OFF_SYNC_STATE, 32'h0);
  endtask

  // second-stage bank: forced long format, hidden table 1, missing registers
  task automatic t_stage2;
    logic [11:0] gone[4];
    gone = '{OFF_ATTR_LO, OFF_ATTR_HI, OFF_SYNC_STATE, OFF_CMD};
    wr(OFF_TBL_CTRL, 32'h0);
    wr(OFF_CONFIG, 32'h1);
    rdc("stage2 control", OFF_TBL_CTRL, 32'h8000_0000);
    wr(OFF_TBL_CTRL, 32'h7fff_0000);
    rdc("stage2 table1 fields", OFF_TBL_CTRL, 32'h8000_0000);
    wr(OFF_TBL1_LO, 32'hffff_ffff);
    rdc("stage2 table1 base", OFF_TBL1_LO, 32'h0);
    settle();
    chk("stage2 format", 64'h1, {63'h0, o_long_format_enable});
    chk("stage2 walk1", 64'h0, {17'h0, o_walk1});
    foreach (gone[i]) begin
      apb(1'b1, gone[i], 32'h1);
      chk("stage2 missing error", 64'h1, {63'h0, er});
    end
    cmd_watch(0, 3'h0);
    wr(OFF_CONFIG, 32'h0);
  endtask

  // report counts and verdict, then stop
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_short();
    t_long();
    t_cmd();
    t_stage2();
    tally_and_finish();
  end

endmodule

`default_nettype wire
